// ### shared/stage_irq_defs.svh
`ifndef STAGE_IRQ_DEFS_SVH
`define STAGE_IRQ_DEFS_SVH
`define UPPER_MASK_ADDR    10'h006
`define DONE_MASK_ADDR     10'h007
`define UPPER_FLAGS_ADDR   10'h009
`define DONE_FLAGS_ADDR    10'h00a
`define MASK_RESET         16'h0000
`define FLAGS_RESET        8'h00
`define STAGE_LSB          0
`define STAGE_MSB          7
`define READ_ZERO          16'h0000
`define PAD_ZERO           8'h00
`define IRQ_IDLE           1'b1
`endif

// ### shared/stage_irq_pkg.sv
package stage_irq_pkg;
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [9:0]  addr;
    logic [15:0] wdata;
  } reg_req_t;
  typedef struct packed {
    logic [7:0] upper_exceeded;
    logic [7:0] conv_done;
  } stage_events_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01
  } rd_state_t;
endpackage : stage_irq_pkg

// ### hdl/mask_regs.sv
`timescale 1ns/100ps
`default_nettype none
`include "stage_irq_defs.svh"
module mask_regs #(
  parameter int WIDTH = 16
) (
  input  wire logic             core_clk,
  input  wire logic             srst,
  input  wire logic             wr_upper,
  input  wire logic             wr_done,
  input  wire logic [WIDTH-1:0] wdata,
  output var  logic [WIDTH-1:0] upper_threshold_irq_mask,
  output var  logic [WIDTH-1:0] conversion_done_irq_mask
);
  logic [WIDTH-1:0] next_upper;
  logic [WIDTH-1:0] next_done;
  if (WIDTH != 16) begin : g_bad_width
    $error("mask_regs needs 16-bit words");
  end
  always_comb begin
    next_upper = upper_threshold_irq_mask;
    next_done  = conversion_done_irq_mask;
    if (wr_upper) next_upper = wdata;
    if (wr_done) next_done = wdata;
  end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      upper_threshold_irq_mask <= `MASK_RESET;
      conversion_done_irq_mask <= `MASK_RESET;
    end else begin
      upper_threshold_irq_mask <= next_upper;
      conversion_done_irq_mask <= next_done;
    end
  end
endmodule : mask_regs
`default_nettype wire

// ### hdl/stage_event_irq_enable.sv
`timescale 1ns/100ps
`default_nettype none
`include "stage_irq_defs.svh"
module stage_event_irq_enable #(
  parameter int STAGES = 8
) (
  input  wire logic                         core_clk,
  input  wire logic                         srst,
  input  wire stage_irq_pkg::reg_req_t      req,
  input  wire stage_irq_pkg::stage_events_t events,
  output var  logic [15:0]                  rdata,
  output var  logic                         rvalid,
  output var  logic                         irq_n
);
  import stage_irq_pkg::*;

  if (STAGES != `STAGE_MSB - `STAGE_LSB + 1) begin : g_bad_stages
    $error("stage_event_irq_enable serves exactly eight stages");
  end
  if (`UPPER_MASK_ADDR == `DONE_MASK_ADDR || `UPPER_FLAGS_ADDR == `DONE_FLAGS_ADDR) begin : g_bad_map
    $error("stage_event_irq_enable register addresses overlap");
  end

  logic [15:0] upper_threshold_irq_mask;
  logic [15:0] conversion_done_irq_mask;
  logic [7:0]  upper_limit_flags;
  logic [7:0]  conversion_done_flags;
  logic [7:0]  next_upper_flags;
  logic [7:0]  next_done_flags;
  logic [15:0] next_rdata;
  logic        next_rvalid;
  logic        next_irq_n;
  rd_state_t   rd_state;
  rd_state_t   next_rd_state;
  logic        rd_upper;
  logic        rd_done;
  logic [7:0]  pend_upper;
  logic [7:0]  pend_done;

  function automatic logic hit(input logic [9:0] a, input logic [9:0] target);
    hit = (a == target);
  endfunction : hit

  // Enable registers
  mask_regs #(.WIDTH(16)) u_masks (
    .core_clk                 (core_clk),
    .srst                     (srst),
    .wr_upper                 (req.wr && hit(req.addr, `UPPER_MASK_ADDR)),
    .wr_done                  (req.wr && hit(req.addr, `DONE_MASK_ADDR)),
    .wdata                    (req.wdata),
    .upper_threshold_irq_mask (upper_threshold_irq_mask),
    .conversion_done_irq_mask (conversion_done_irq_mask)
  );

  // Reads of the flag registers clear them
  assign rd_upper = req.rd && hit(req.addr, `UPPER_FLAGS_ADDR);
  assign rd_done  = req.rd && hit(req.addr, `DONE_FLAGS_ADDR);

  // Register read port
  always_comb begin
    next_rdata = `READ_ZERO;
    if (!req.rd) begin
      next_rdata = rdata;
    end else if (hit(req.addr, `UPPER_MASK_ADDR)) begin
      next_rdata = upper_threshold_irq_mask;
    end else if (hit(req.addr, `DONE_MASK_ADDR)) begin
      next_rdata = conversion_done_irq_mask;
    end else if (hit(req.addr, `UPPER_FLAGS_ADDR)) begin
      next_rdata = {`PAD_ZERO, upper_limit_flags};
    end else if (hit(req.addr, `DONE_FLAGS_ADDR)) begin
      next_rdata = {`PAD_ZERO, conversion_done_flags};
    end
    next_rvalid   = req.rd;
    next_rd_state = req.rd ? ST_READ : ST_IDLE;
  end

  // Per-stage event flags
  genvar g;
  generate
    for (g = `STAGE_LSB; g <= `STAGE_MSB; g++) begin : g_flag
      always_comb begin
        // Set wins over read clear; a lasting limit keeps the flag up
        next_upper_flags[g] = events.upper_exceeded[g] | (upper_limit_flags[g] & ~rd_upper);
        next_done_flags[g]  = events.conv_done[g] | (conversion_done_flags[g] & ~rd_done);
      end
    end
  endgenerate

  // Interrupt output
  always_comb begin
    pend_upper = next_upper_flags & upper_threshold_irq_mask[`STAGE_MSB:`STAGE_LSB];
    pend_done  = next_done_flags & conversion_done_irq_mask[`STAGE_MSB:`STAGE_LSB];
    next_irq_n = ~((|pend_upper) | (|pend_done));
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      irq_n <= `IRQ_IDLE;
    end else begin
      irq_n <= next_irq_n;
    end
  end

  // Flag registers
  always_ff @(posedge core_clk) begin
    if (srst) begin
      upper_limit_flags     <= `FLAGS_RESET;
      conversion_done_flags <= `FLAGS_RESET;
    end else begin
      upper_limit_flags     <= next_upper_flags;
      conversion_done_flags <= next_done_flags;
    end
  end

  // Read port registers
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rdata    <= `READ_ZERO;
      rvalid   <= 1'b0;
      rd_state <= ST_IDLE;
    end else begin
      rdata    <= next_rdata;
      rvalid   <= next_rvalid;
      rd_state <= next_rd_state;
    end
  end

  // Checks; the interrupt uses the enables as they stood at the edge that took the event
  a_irq_follows_flags: assert property (@(posedge core_clk) disable iff (srst)
    irq_n == ~(|(upper_limit_flags & $past(upper_threshold_irq_mask[7:0])) |
               |(conversion_done_flags & $past(conversion_done_irq_mask[7:0]))))
    else $error("irq_n does not match pending enabled events");
  a_masked_quiet: assert property (@(posedge core_clk) disable iff (srst)
    (upper_threshold_irq_mask[7:0] == 8'h00 && conversion_done_irq_mask[7:0] == 8'h00) |=> irq_n)
    else $error("interrupt asserted with all enables clear");
  a_upper_event_irq: assert property (@(posedge core_clk) disable iff (srst)
    (|(events.upper_exceeded & upper_threshold_irq_mask[7:0]) && !req.wr) |=> !irq_n)
    else $error("enabled upper event did not assert interrupt");
  a_done_event_irq: assert property (@(posedge core_clk) disable iff (srst)
    (|(events.conv_done & conversion_done_irq_mask[7:0]) && !req.wr) |=> !irq_n)
    else $error("enabled completion event did not assert interrupt");
  a_read_clears: assert property (@(posedge core_clk) disable iff (srst)
    (rd_done && events.conv_done == 8'h00) |=> conversion_done_flags == 8'h00)
    else $error("completion flags not cleared by readback");
  a_limit_holds: assert property (@(posedge core_clk) disable iff (srst)
    (rd_upper && events.upper_exceeded[0]) |=> upper_limit_flags[0])
    else $error("upper flag cleared while limit present");
  a_upper_mask_rw: assert property (@(posedge core_clk) disable iff (srst)
    (req.wr && req.addr == `UPPER_MASK_ADDR) |=> upper_threshold_irq_mask == $past(req.wdata))
    else $error("upper mask write lost");
  a_done_mask_rw: assert property (@(posedge core_clk) disable iff (srst)
    (req.wr && req.addr == `DONE_MASK_ADDR) |=> conversion_done_irq_mask == $past(req.wdata))
    else $error("done mask write lost");
  a_read_back: assert property (@(posedge core_clk) disable iff (srst)
    (req.rd && req.addr == `UPPER_MASK_ADDR && !req.wr) |=> rvalid && rdata == upper_threshold_irq_mask)
    else $error("upper mask readback wrong");
  a_reset_values: assert property (@(posedge core_clk)
    srst |=> (upper_threshold_irq_mask == `MASK_RESET && conversion_done_irq_mask == `MASK_RESET && irq_n))
    else $error("reset left an enable set or the interrupt asserted");
  a_done_read_back: assert property (@(posedge core_clk) disable iff (srst)
    (req.rd && req.addr == `DONE_MASK_ADDR && !req.wr) |=> rvalid && rdata == conversion_done_irq_mask)
    else $error("completion mask readback wrong");
  a_upper_flag_read: assert property (@(posedge core_clk) disable iff (srst)
    rd_upper |=> rvalid && rdata == {`PAD_ZERO, $past(upper_limit_flags)})
    else $error("upper flags readback wrong");
  a_done_flag_read: assert property (@(posedge core_clk) disable iff (srst)
    rd_done |=> rvalid && rdata == {`PAD_ZERO, $past(conversion_done_flags)})
    else $error("completion flags readback wrong");
  a_rvalid_follows: assert property (@(posedge core_clk) disable iff (srst)
    1'b1 |=> rvalid == $past(req.rd))
    else $error("read valid does not follow the read strobe");
  a_rdata_holds: assert property (@(posedge core_clk) disable iff (srst)
    !req.rd |=> $stable(rdata))
    else $error("read data changed without a read");
  a_unmapped_zero: assert property (@(posedge core_clk) disable iff (srst)
    (req.rd && req.addr != `UPPER_MASK_ADDR && req.addr != `DONE_MASK_ADDR &&
     req.addr != `UPPER_FLAGS_ADDR && req.addr != `DONE_FLAGS_ADDR) |=> rdata == `READ_ZERO)
    else $error("unmapped read returned data");
  a_upper_read_clears: assert property (@(posedge core_clk) disable iff (srst)
    (rd_upper && events.upper_exceeded == 8'h00) |=> upper_limit_flags == 8'h00)
    else $error("upper flags not cleared by readback");
  a_irq_release: assert property (@(posedge core_clk) disable iff (srst)
    (upper_limit_flags == 8'h00 && conversion_done_flags == 8'h00 && events == '0) |=> irq_n)
    else $error("interrupt asserted with nothing pending");
  a_masks_hold: assert property (@(posedge core_clk) disable iff (srst)
    !req.wr |=> $stable(upper_threshold_irq_mask) && $stable(conversion_done_irq_mask))
    else $error("enable register changed without a write");

  // Per-stage checks
  generate
    for (g = `STAGE_LSB; g <= `STAGE_MSB; g++) begin : g_stage_check
      a_upper_sticks: assert property (@(posedge core_clk) disable iff (srst)
        (upper_limit_flags[g] && !rd_upper) |=> upper_limit_flags[g])
        else $error("upper flag dropped without a read");
      a_done_sticks: assert property (@(posedge core_clk) disable iff (srst)
        (conversion_done_flags[g] && !rd_done) |=> conversion_done_flags[g])
        else $error("completion flag dropped without a read");
      a_upper_masked: assert property (@(posedge core_clk) disable iff (srst)
        (events.upper_exceeded == (8'h01 << g) && !upper_threshold_irq_mask[g] &&
         events.conv_done == 8'h00 && upper_limit_flags == 8'h00 && conversion_done_flags == 8'h00) |=> irq_n)
        else $error("masked upper event asserted the interrupt");
      a_done_masked: assert property (@(posedge core_clk) disable iff (srst)
        (events.conv_done == (8'h01 << g) && !conversion_done_irq_mask[g] &&
         events.upper_exceeded == 8'h00 && upper_limit_flags == 8'h00 && conversion_done_flags == 8'h00) |=> irq_n)
        else $error("masked completion event asserted the interrupt");
    end
  endgenerate

  // Scenario covers
  c_irq_low: cover property (@(posedge core_clk) disable iff (srst) $fell(irq_n));
  c_irq_release: cover property (@(posedge core_clk) disable iff (srst) $rose(irq_n));
  c_read_flags: cover property (@(posedge core_clk) disable iff (srst) rd_upper && |upper_limit_flags);
  c_read_state: cover property (@(posedge core_clk) disable iff (srst) rd_state == ST_READ);
  c_held_limit: cover property (@(posedge core_clk) disable iff (srst) rd_upper && |events.upper_exceeded);
endmodule : stage_event_irq_enable
`default_nettype wire

// ### test/host_model.sv
`timescale 1ns/100ps
`default_nettype none
`include "stage_irq_defs.svh"
module host_model (
  input  wire logic                    core_clk,
  input  wire logic [15:0]             rdata,
  input  wire logic                    rvalid,
  output var  stage_irq_pkg::reg_req_t req
);
  import stage_irq_pkg::*;
  int n_timeout = 0;
  initial req = '0;
  // Write strobe for one cycle, unused bits sent as zero
  task automatic wr(input logic [9:0] a, input logic [15:0] v);
    @(posedge core_clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: {8'h00, v[7:0]}};
    @(posedge core_clk);
    req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~v};
  endtask : wr
  // Read strobe for one cycle, data taken with the valid pulse
  task automatic rd(input logic [9:0] a, output logic [15:0] v);
    int i;
    @(posedge core_clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge core_clk);
    req.rd <= 1'b0;
    #1;
    for (i = 0; i < 4 && rvalid !== 1'b1; i++) begin
      @(posedge core_clk);
      #1;
    end
    if (rvalid !== 1'b1) n_timeout++;
    v = (rvalid === 1'b1) ? rdata : 16'hxxxx;
  endtask : rd
endmodule : host_model
`default_nettype wire

// ### test/stage_event_irq_enable_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "stage_irq_defs.svh"
module stage_event_irq_enable_tb;
  import stage_irq_pkg::*;
  logic          core_clk = 1'b0;
  logic          srst     = 1'b1;
  stage_events_t ev       = '0;
  reg_req_t      req;
  logic [15:0]   rdata;
  logic [15:0]   d;
  logic          rvalid;
  logic          irq_n;
  int            n_mismatch = 0;
  int            n_tests    = 0;
  stage_event_irq_enable uut (.core_clk(core_clk), .srst(srst), .req(req), .events(ev),
                              .rdata(rdata), .rvalid(rvalid), .irq_n(irq_n));
  host_model h (.core_clk(core_clk), .rdata(rdata), .rvalid(rvalid), .req(req));
  initial forever #50 core_clk = ~core_clk;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // One-cycle event pulse, returns just after the edge that takes it
  task automatic pulse(input int k, input logic [7:0] s);
    @(posedge core_clk);
    if (k == 0) ev.upper_exceeded <= s;
    else ev.conv_done <= s;
    @(posedge core_clk);
    ev <= '0;
    #1;
  endtask : pulse
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  initial begin
    for (int i = 0; i < 20000 && h.n_timeout == 0; i++) @(posedge core_clk);
    n_mismatch++;
    stop_test();
  end
  initial begin
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    h.rd(`UPPER_MASK_ADDR, d);
    check(d, `MASK_RESET);
    h.rd(`DONE_MASK_ADDR, d);
    check(d, `MASK_RESET);
    h.wr(`UPPER_MASK_ADDR, 16'h00a5);
    h.wr(`DONE_MASK_ADDR, 16'h005a);
    h.wr(`UPPER_FLAGS_ADDR, 16'h00ff);
    h.rd(`UPPER_MASK_ADDR, d);
    check(d, 16'h00a5);
    h.rd(`DONE_MASK_ADDR, d);
    check(d, 16'h005a);
    h.rd(10'h0ff, d);
    check(d, `READ_ZERO);
    $display("test registers done");
    for (int k = 0; k < 2; k++) begin
      for (int n = 0; n < 8; n++) begin
        h.wr(k ? `DONE_MASK_ADDR : `UPPER_MASK_ADDR, 16'h0001 << n);
        pulse(k, 8'h01 << ((n + 1) % 8));
        check({15'h0, irq_n}, 16'h0001);
        pulse(k, 8'h01 << n);
        check({15'h0, irq_n}, 16'h0000);
        h.rd(k ? `DONE_FLAGS_ADDR : `UPPER_FLAGS_ADDR, d);
        check(d, (16'h0001 << n) | (16'h0001 << ((n + 1) % 8)));
        @(posedge core_clk);
        #1;
        check({15'h0, irq_n}, 16'h0001);
        check({15'h0, rvalid}, 16'h0000);
        h.rd(k ? `DONE_FLAGS_ADDR : `UPPER_FLAGS_ADDR, d);
        check(d, 16'h0000);
      end
    end
    $display("test stage events done");
    h.wr(`UPPER_MASK_ADDR, 16'h0001);
    ev.upper_exceeded <= 8'h01;
    h.rd(`UPPER_FLAGS_ADDR, d);
    check(d, 16'h0001);
    h.rd(`UPPER_FLAGS_ADDR, d);
    check(d, 16'h0001);
    check({15'h0, irq_n}, 16'h0000);
    @(posedge core_clk);
    ev <= '0;
    h.rd(`UPPER_FLAGS_ADDR, d);
    check(d, 16'h0001);
    h.rd(`UPPER_FLAGS_ADDR, d);
    check(d, 16'h0000);
    $display("test held condition done");
    stop_test();
  end
endmodule : stage_event_irq_enable_tb
`default_nettype wire
